// ===== shared/acmc_pkg.sv
// Purpose: shared constants and types for the converter mode control block
// Assumes: 8-bit special function register reached over the core's own register port
// Notes: field positions, reset value and channel codes live here only
package acmc_pkg;

  // register layout
  localparam int ACMC_DATA_W = 8;
  localparam int ACMC_CS_W = 4;
  localparam int ACMC_SEL_W = 12;
  localparam int ACMC_RES_W = 12;
  localparam int ACMC_BIT_DONE = 7;
  localparam int ACMC_BIT_DMA = 6;
  localparam int ACMC_BIT_CONTINUOUS_CONVERT_BIT = 5;
  localparam int ACMC_BIT_SINGLE_CONVERT_BIT = 4;
  localparam int ACMC_CS_HI = 3;
  localparam int ACMC_CS_LO = 0;
  localparam logic [ACMC_DATA_W-1:0] ACMC_MODE_RESET = 8'h00;

  // channel codes in the select field
  localparam logic [ACMC_CS_W-1:0] ACMC_CH_LAST_EXT = 4'h7;
  localparam logic [ACMC_CS_W-1:0] ACMC_CH_TEMP = 4'h8;
  localparam logic [ACMC_CS_W-1:0] ACMC_CH_DAC0 = 4'h9;
  localparam logic [ACMC_CS_W-1:0] ACMC_CH_DAC1 = 4'ha;
  localparam logic [ACMC_CS_W-1:0] ACMC_CH_AGND = 4'hb;
  localparam int ACMC_SEL_TEMP = 8;
  localparam int ACMC_SEL_DAC0 = 9;
  localparam int ACMC_SEL_DAC1 = 10;
  localparam int ACMC_SEL_AGND = 11;

  // result byte layout: channel code in the top nibble of the high byte
  localparam int ACMC_RES_HI_MSB = 11;
  localparam int ACMC_RES_HI_LSB = 8;
  localparam int ACMC_RES_LO_MSB = 7;

  typedef enum logic [1:0] {
    ACMC_IDLE,
    ACMC_CONVERT,
    ACMC_DMA_FETCH,
    ACMC_DMA_CONVERT
  } acmc_state_t;

  // software-visible mode register
  typedef struct packed {
    logic done_flag;
    logic dma_enable;
    logic continuous;
    logic single;
    logic [ACMC_CS_W-1:0] chan_sel;
  } acmc_mode_t;

  // converter-facing request
  typedef struct packed {
    logic start;
    logic [ACMC_CS_W-1:0] chan;
    logic [ACMC_SEL_W-1:0] mux_sel;
  } acmc_conv_req_t;

  // result bytes handed to the result registers or the dma writer
  typedef struct packed {
    logic valid;
    logic [ACMC_DATA_W-1:0] high_byte;
    logic [ACMC_DATA_W-1:0] low_byte;
  } acmc_result_t;

  // whole state of the block
  typedef struct packed {
    acmc_state_t state;
    acmc_mode_t mode;
    logic single_run;
    logic dma_id_req;
    acmc_conv_req_t conv;
    acmc_result_t result;
  } acmc_regs_t;

endpackage

// ===== core/acmc_mode_control.sv
// Purpose: conversion mode control register and conversion sequencer
// Assumes: converter core, dma channel fetch and interrupt logic all run on clk
// Notes: the register is read and written through the core's 8-bit register port
//
// Notes on behaviour
// - done flag set at single or dma-block end
// - done flag cleared when interrupt is vectored
// - writing dma bit starts prepared dma conversions
// - dma bit clears itself when dma completes
// - address strobe stops until dma actually starts
// - continuous bit restarts conversion after each completion
// - single bit launches exactly one conversion
// - single bit clears itself on completion
// - non-dma conversion uses current channel select field
// - dma ignores field, uses channel id fetched
// - channel field decoded as binary input number
// - register resets to all zeros
// - codes 0-7 inputs, then temp, dac0, dac1, ground
// - channel code placed in result high nibble
`timescale 1ns/1ps

// limitations a user should know:
//   the converter must answer every start with exactly one done pulse
//   a done pulse outside a conversion is dropped, never queued
//   channel codes twelve to fifteen start a conversion with no input selected
//   single and continuous together run continuously; single drops at the first end
//   the dma memory side owns the end of a block through its end marker
//   the done flag is only set per dma block, not per dma sample
module acmc_mode_control
  import acmc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sfr_wr,
  input wire logic [ACMC_DATA_W-1:0] sfr_wdata,
  output logic [ACMC_DATA_W-1:0] sfr_rdata,
  input wire logic int_vector_ack,
  output logic conversion_done_flag,
  output logic conv_start,
  output logic [ACMC_CS_W-1:0] conv_channel,
  output logic [ACMC_SEL_W-1:0] conv_mux_sel,
  input wire logic conv_done,
  input wire logic [ACMC_RES_W-1:0] conv_data,
  output logic dma_id_req,
  input wire logic dma_id_valid,
  input wire logic dma_id_end,
  input wire logic [ACMC_CS_W-1:0] dma_id,
  output logic result_valid,
  output logic [ACMC_DATA_W-1:0] result_high_byte,
  output logic [ACMC_DATA_W-1:0] result_low_byte,
  output logic dma_active,
  input wire logic ale_in,
  output logic ale_out
);

  acmc_regs_t r_reg;
  acmc_regs_t r_next;

  // binary channel code to one-hot multiplexer select
  function automatic logic [ACMC_SEL_W-1:0] acmc_decode(input logic [ACMC_CS_W-1:0] code);
    logic [ACMC_SEL_W-1:0] sel;
    sel = '0;
    if (code <= ACMC_CH_LAST_EXT) begin
      sel[code] = 1'b1;
    end else begin
      unique case (code)
        ACMC_CH_TEMP: sel[ACMC_SEL_TEMP] = 1'b1;
        ACMC_CH_DAC0: sel[ACMC_SEL_DAC0] = 1'b1;
        ACMC_CH_DAC1: sel[ACMC_SEL_DAC1] = 1'b1;
        ACMC_CH_AGND: sel[ACMC_SEL_AGND] = 1'b1;
        default: sel = '0; // unused codes select nothing
      endcase
    end
    return sel;
  endfunction

  // one conversion request, channel frozen for the whole conversion
  function automatic acmc_conv_req_t acmc_launch(input logic [ACMC_CS_W-1:0] code);
    acmc_conv_req_t req;
    req.start = 1'b1;
    req.chan = code;
    req.mux_sel = acmc_decode(code);
    return req;
  endfunction

  // result bytes tagged with the channel that produced them
  function automatic acmc_result_t acmc_pack(input logic [ACMC_CS_W-1:0] code,
                                             input logic [ACMC_RES_W-1:0] data);
    acmc_result_t res;
    res.valid = 1'b1;
    res.high_byte = {code, data[ACMC_RES_HI_MSB:ACMC_RES_HI_LSB]};
    res.low_byte = data[ACMC_RES_LO_MSB:0];
    return res;
  endfunction

  // dma counts as running from the first fetch until the end marker returns to idle
  function automatic logic acmc_in_dma(input acmc_state_t st);
    logic busy;
    busy = 1'b0;
    unique case (st)
      ACMC_IDLE: busy = 1'b0;
      ACMC_CONVERT: busy = 1'b0;
      ACMC_DMA_FETCH: busy = 1'b1;
      ACMC_DMA_CONVERT: busy = 1'b1;
    endcase
    return busy;
  endfunction

  // done flag arbitration: a completion beats any clear in the same cycle,
  // so software clearing late can never lose an end of conversion
  function automatic logic acmc_flag_next(input logic cur,
                                          input logic set_evt,
                                          input logic clr_evt,
                                          input logic wr_evt,
                                          input logic wr_bit);
    logic nxt;
    nxt = cur;
    if (set_evt) begin
      nxt = 1'b1;
    end else if (clr_evt) begin
      nxt = 1'b0;
    end else if (wr_evt) begin
      nxt = cur | wr_bit;
    end
    return nxt;
  endfunction

  // address strobe gate: quiet only between arming dma and the first fetch
  function automatic logic acmc_ale_gate(input logic strobe,
                                         input logic dma_armed,
                                         input logic dma_running);
    logic pass;
    pass = strobe & ~(dma_armed & ~dma_running);
    return pass;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic set_done;
    logic clear_done;
    logic clear_dma;
    logic clear_single;
    set_done = 1'b0;
    clear_done = 1'b0;
    clear_dma = 1'b0;
    clear_single = 1'b0;
    r_next = r_reg;
    r_next.conv.start = 1'b0;
    r_next.result.valid = 1'b0;

    // software write: all fields take the written value
    if (sfr_wr) begin
      r_next.mode = sfr_wdata;
      clear_done = ~sfr_wdata[ACMC_BIT_DONE];
    end
    // vectoring to the service routine clears the flag
    if (int_vector_ack) begin
      clear_done = 1'b1;
    end

    unique case (r_reg.state)
      ACMC_IDLE: begin
        if (r_reg.mode.dma_enable) begin
          // dma start: channel comes from memory, not the field
          r_next.state = ACMC_DMA_FETCH;
          r_next.dma_id_req = 1'b1;
        end else if (r_reg.mode.continuous || r_reg.mode.single) begin
          r_next.conv = acmc_launch(r_reg.mode.chan_sel);
          r_next.single_run = ~r_reg.mode.continuous;
          r_next.state = ACMC_CONVERT;
        end
      end
      ACMC_CONVERT: begin
        if (conv_done) begin
          r_next.result = acmc_pack(r_reg.conv.chan, conv_data);
          set_done = 1'b1;
          if (r_reg.mode.single) begin
            clear_single = 1'b1;
          end
          // continuous mode chains straight into the next conversion
          if (r_reg.mode.continuous && !(sfr_wr && !sfr_wdata[ACMC_BIT_CONTINUOUS_CONVERT_BIT])) begin
            r_next.conv = acmc_launch(r_reg.mode.chan_sel);
            r_next.single_run = 1'b0;
          end else begin
            r_next.state = ACMC_IDLE;
            r_next.single_run = 1'b0;
          end
        end
      end
      ACMC_DMA_FETCH: begin
        if (dma_id_valid) begin
          r_next.dma_id_req = 1'b0;
          if (dma_id_end) begin
            // end marker closes the block
            set_done = 1'b1;
            clear_dma = 1'b1;
            r_next.state = ACMC_IDLE;
          end else begin
            r_next.conv = acmc_launch(dma_id);
            r_next.state = ACMC_DMA_CONVERT;
          end
        end
      end
      ACMC_DMA_CONVERT: begin
        if (conv_done) begin
          r_next.result = acmc_pack(r_reg.conv.chan, conv_data);
          r_next.dma_id_req = 1'b1;
          r_next.state = ACMC_DMA_FETCH;
        end
      end
    endcase

    // hardware clears of self-clearing bits win over a same-cycle write
    if (clear_single) begin
      r_next.mode.single = 1'b0;
    end
    if (clear_dma) begin
      r_next.mode.dma_enable = 1'b0;
    end
    // a completion in the clearing cycle is not lost: set wins
    r_next.mode.done_flag = acmc_flag_next(r_reg.mode.done_flag,
                                           set_done,
                                           clear_done,
                                           sfr_wr,
                                           sfr_wdata[ACMC_BIT_DONE]);
  end

  // single state register, cleared to zero at reset
  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= '{state: ACMC_IDLE, mode: ACMC_MODE_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // register read-back straight from the flops, no read side effects
  assign sfr_rdata = r_reg.mode;
  assign conversion_done_flag = r_reg.mode.done_flag;

  // converter request; channel and select hold until the next start
  assign conv_start = r_reg.conv.start;
  assign conv_channel = r_reg.conv.chan;
  assign conv_mux_sel = r_reg.conv.mux_sel;

  // channel id fetch request towards the dma memory side
  assign dma_id_req = r_reg.dma_id_req;

  // tagged result bytes, valid for one cycle, bytes hold afterwards
  assign result_valid = r_reg.result.valid;
  assign result_high_byte = r_reg.result.high_byte;
  assign result_low_byte = r_reg.result.low_byte;

  // dma status decoded from the state flops only, so it never glitches
  assign dma_active = acmc_in_dma(r_reg.state);

  // strobe held off between setting the dma bit and dma actually running;
  // combinational so the core's strobe timing is not delayed by a cycle
  assign ale_out = acmc_ale_gate(ale_in, r_reg.mode.dma_enable, dma_active);

endmodule

// ===== dv/acmc_mode_control_props.sv
// Purpose: port checks of the mode control block
// Assumes: one clock, synchronous active-high reset
// Notes: busy_reg marks an open conversion
`timescale 1ns/1ps
module acmc_mode_control_props
  import acmc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic int_vector_ack,
  input wire logic conversion_done_flag,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic [11:0] conv_mux_sel,
  input wire logic conv_done,
  input wire logic dma_id_req,
  input wire logic dma_id_valid,
  input wire logic dma_id_end,
  input wire logic [3:0] dma_id,
  input wire logic result_valid,
  input wire logic [7:0] result_high_byte,
  input wire logic dma_active,
  input wire logic ale_in,
  input wire logic ale_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic busy_reg;
  // stray converter pulses outside a conversion must not count
  always_ff @(posedge clk) begin
    if (reset) busy_reg <= 1'h0;
    else if (conv_start) busy_reg <= 1'h1;
    else if (result_valid) busy_reg <= 1'h0;
  end
  sequence wr_single;
    sfr_wr && sfr_wdata[6:4] == 3'h1 && sfr_rdata[6:4] == 3'h0 && !busy_reg && !conv_start;
  endsequence
  sequence id_taken;
    dma_id_req && dma_id_valid;
  endsequence
  reset_zero_a: assert property ($fell(reset) |-> sfr_rdata == 8'h00)
    else $error("register not zero after reset");
  single_start_a: assert property (wr_single |-> ##2 conv_start && conv_channel == $past(sfr_wdata[3:0], 2))
    else $error("single start wrong");
  done_set_a: assert property (result_valid && !dma_active |-> conversion_done_flag && !sfr_rdata[4])
    else $error("done flag or single bit wrong");
  vector_clear_a: assert property (int_vector_ack && !sfr_wr && !conv_done && !dma_id_valid |=> !conversion_done_flag)
    else $error("flag kept after vector");
  chain_a: assert property (conv_done && busy_reg && !dma_active && !sfr_wr && sfr_rdata[5]
    |=> conv_start && conv_channel == $past(sfr_rdata[3:0]))
    else $error("continuous restart wrong");
  one_shot_a: assert property (conv_done && busy_reg && !dma_active && !sfr_wr && !sfr_rdata[5] |=> !conv_start)
    else $error("extra conversion");
  dma_begin_a: assert property ($rose(sfr_rdata[6]) && !busy_reg && !dma_active |=> dma_id_req && dma_active)
    else $error("dma did not begin");
  dma_chan_a: assert property (id_taken and !dma_id_end |=> conv_start && !dma_id_req && conv_channel == $past(dma_id))
    else $error("dma channel wrong");
  dma_end_a: assert property (id_taken and dma_id_end |=> !sfr_rdata[6] && conversion_done_flag && !dma_active)
    else $error("dma end wrong");
  ale_gate_a: assert property (ale_out == (ale_in && !(sfr_rdata[6] && !dma_active)))
    else $error("address strobe gating wrong");
  mux_decode_a: assert property (conv_start |-> conv_mux_sel == (conv_channel < 4'hc ? 12'h1 << conv_channel : 12'h0))
    else $error("mux select wrong");
  result_tag_a: assert property (result_valid |-> result_high_byte[7:4] == $past(conv_channel))
    else $error("result channel wrong");
endmodule
bind acmc_mode_control acmc_mode_control_props props (.*);

// ===== dv/adc_conversion_mode_control_test.sv
// Purpose: self-checking bench of the mode control block
// Assumes: bench answers for converter and dma memory
// Notes: converter answers after a few cycles with random data
`timescale 1ns/1ps
module adc_conversion_mode_control_test;
  import acmc_pkg::*;
  logic clk = 1'h0, reset = 1'h1, sfr_wr = 1'h0, int_vector_ack = 1'h0, conv_done = 1'h0;
  logic dma_id_valid = 1'h0, dma_id_end = 1'h0, ale_in = 1'h0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [11:0] conv_data = 12'h000;
  logic [3:0] dma_id = 4'h0;
  logic [3:0] id;
  logic [7:0] sfr_rdata, result_high_byte, result_low_byte;
  logic [3:0] conv_channel;
  logic [11:0] conv_mux_sel;
  logic conversion_done_flag, conv_start, dma_id_req, result_valid, dma_active, ale_out;
  int num_errors = 0, n_tests = 0, seed = 15013;
  acmc_mode_control dut (.*);
  // clock and a random core address strobe
  initial forever #4 clk = ~clk;
  always @(posedge clk) ale_in <= 1'($random(seed));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait, sampled at the falling edge where outputs are settled
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    while (s !== 1'h1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    if (k == 60) begin
      num_errors++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'h1;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'h0;
  endtask
  // one conversion; mid is an optional write made while it runs
  task automatic conv(input logic [3:0] ch, input logic [7:0] mid);
    logic [11:0] d;
    d = 12'($random(seed));
    wait_hi(conv_start);
    check(16'(conv_channel), 16'(ch));
    check(conv_mux_sel, ch < 4'hc ? 16'h1 << ch : 16'h0);
    if (mid != 8'h00) wr(mid);
    repeat (2) @(posedge clk);
    conv_done <= 1'h1;
    conv_data <= d;
    @(posedge clk);
    conv_done <= 1'h0;
    @(negedge clk);
    check(16'(result_valid), 16'h1);
    check({result_high_byte, result_low_byte}, {ch, d});
  endtask
  task automatic dma_ans(input logic [3:0] v, input logic last);
    wait_hi(dma_id_req);
    @(posedge clk);
    dma_id_valid <= 1'h1;
    dma_id_end <= last;
    dma_id <= v;
    @(posedge clk);
    dma_id_valid <= 1'h0;
    dma_id_end <= 1'h0;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    @(negedge clk);
    check(16'(sfr_rdata), 16'(ACMC_MODE_RESET));
    // every channel code once, flag cleared by vector or by write
    for (int c = 0; c < 16; c++) begin
      wr({4'h1, 4'(c)});
      conv(4'(c), 8'h00);
      check(16'(sfr_rdata), {8'h00, 4'h8, 4'(c)});
      if (c[0]) begin
        @(posedge clk);
        int_vector_ack <= 1'h1;
        @(posedge clk);
        int_vector_ack <= 1'h0;
      end else begin
        wr({4'h0, 4'(c)});
      end
      @(negedge clk);
      check(16'(conversion_done_flag), 16'h0);
    end
    // continuous chain, channel change mid-run, then stop
    wr(8'h23);
    conv(4'h3, 8'h26);
    conv(4'h6, 8'h06);
    check(16'({conv_start, sfr_rdata}), 16'h086);
    // dma ignores the field and takes ids from memory
    wr(8'h4a);
    for (int k = 0; k < 3; k++) begin
      id = 4'({$random(seed)} % 12);
      dma_ans(id, 1'h0);
      conv(id, 8'h00);
    end
    check(16'(sfr_rdata), 16'h4a);
    dma_ans(4'h0, 1'h1);
    @(negedge clk);
    check(16'({dma_active, sfr_rdata}), 16'h08a);
    complete_run;
  end
endmodule
